// *** rtl/icce_pkg.sv ***
// Purpose: Shared constants and types of the serial client engine
// Assumes: Byte-oriented two-wire bus, client role only
// Notes:   Mode bits select addressing width and condition events

package icce_pkg;

	// ****************************************************************
	// Widths and field positions
	// ****************************************************************
	localparam int          BYTE_W        = 8;
	localparam int          CNT_W         = 4;
	localparam int          MODE_W        = 2;
	localparam int          MODE_TEN_BIT  = 0;
	localparam int          MODE_EVENTS   = 1;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [3:0]  LAST_TX_FALL  = 4'h7;
	localparam logic [4:0]  TEN_HI_PREFIX = 5'h1e;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic              FLAG_RST     = 1'b0;
	localparam logic              RELEASE_RST  = 1'b1;
	localparam logic              PIN_IDLE_RST = 1'b1;
	localparam logic              PIN_LOW      = 1'b0;
	localparam logic [BYTE_W-1:0] BYTE_RST     = 8'h00;
	localparam logic [CNT_W-1:0]  CNT_RST      = 4'h0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_RX    = 3'b001,
		ST_ACK   = 3'b010,
		ST_TX    = 3'b011,
		ST_TXACK = 3'b100
	} icce_state_t;

	typedef enum logic [1:0]
	{
		KIND_ADDR = 2'b00,
		KIND_LOW  = 2'b01,
		KIND_DATA = 2'b10
	} icce_kind_t;

endpackage

// *** rtl/icce_link_if.sv ***
// Purpose: Carries sampled bus levels, edges and address compares
// Assumes: All signals live in the mclk domain
// Notes:   det drives pin events, cmp answers address compares
`timescale 1ns/1ps

interface icce_link_if;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic [7:0] rx_byte;
	logic [7:0] own_addr;
	logic       hi_ok;
	logic       seven_ok;
	logic       low_ok;

	modport det
	(
		output scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det
	);
	modport cmp
	(
		input  rx_byte, own_addr,
		output hi_ok, seven_ok, low_ok
	);
	modport eng
	(
		input  scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det,
		input  hi_ok, seven_ok, low_ok,
		output rx_byte, own_addr
	);
endinterface

// *** rtl/icce_cond.sv ***
// Purpose: Synchronises bus pins and finds edges, Start and Stop
// Assumes: Pins are asynchronous to mclk
// Notes:   Stop counts only after a low clock phase since the last
//          condition
`timescale 1ns/1ps

module icce_cond
	import icce_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic scl_in,
	input  wire logic sda_in,
	icce_link_if.det  lnk
);
	logic scl_s1_reg;
	logic scl_s2_reg;
	logic scl_d_reg;
	logic sda_s1_reg;
	logic sda_s2_reg;
	logic sda_d_reg;
	logic low_seen_reg;
	logic low_seen_next;
	logic start_c;
	logic stop_c;

	// ****************************************************************
	// Conditions
	// ****************************************************************
	assign start_c = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign stop_c  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg
		& low_seen_reg;

	always_comb
	begin
		low_seen_next = low_seen_reg;
		if (start_c || stop_c)
			low_seen_next = FLAG_RST;
		else if (!scl_s2_reg)
			low_seen_next = 1'b1;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			scl_s1_reg   <= PIN_IDLE_RST;
			scl_s2_reg   <= PIN_IDLE_RST;
			scl_d_reg    <= PIN_IDLE_RST;
			sda_s1_reg   <= PIN_IDLE_RST;
			sda_s2_reg   <= PIN_IDLE_RST;
			sda_d_reg    <= PIN_IDLE_RST;
			low_seen_reg <= FLAG_RST;
		end
		else if (ce)
		begin
			scl_s1_reg   <= scl_in;
			scl_s2_reg   <= scl_s1_reg;
			scl_d_reg    <= scl_s2_reg;
			sda_s1_reg   <= sda_in;
			sda_s2_reg   <= sda_s1_reg;
			sda_d_reg    <= sda_s2_reg;
			low_seen_reg <= low_seen_next;
		end
	end

	assign lnk.scl_s     = scl_s2_reg;
	assign lnk.sda_s     = sda_s2_reg;
	assign lnk.scl_rise  = scl_s2_reg & ~scl_d_reg;
	assign lnk.scl_fall  = ~scl_s2_reg & scl_d_reg;
	assign lnk.start_det = start_c;
	assign lnk.stop_det  = stop_c;
endmodule

// *** rtl/icce_match.sv ***
// Purpose: Compares a received byte against the own address
// Assumes: Compare results are read on the eighth falling edge
// Notes:   Purely combinational
`timescale 1ns/1ps

module icce_match
	import icce_pkg::*;
(
	icce_link_if.cmp lnk
);
	// ****************************************************************
	// Compares
	// ****************************************************************
	assign lnk.hi_ok    = (lnk.rx_byte[7:3] == TEN_HI_PREFIX)
		&& (lnk.rx_byte[2:1] == lnk.own_addr[2:1]);
	assign lnk.seven_ok = lnk.rx_byte[7:1] == lnk.own_addr[7:1];
	assign lnk.low_ok   = lnk.rx_byte == lnk.own_addr;
endmodule

// *** rtl/icce_client.sv ***
// Purpose: Client engine of a byte-oriented two-wire serial port
// Assumes: External host drives SCL; pins are open drain
// Notes:   Software controls are plain ports; *_we, *_re, *_set and
//          *_clr inputs are one-cycle pulses
`timescale 1ns/1ps

module icce_client
	import icce_pkg::*;
(
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          ce,
	input  wire logic                          scl_in,
	output logic                               scl_out,
	output logic                               scl_oe_n,
	input  wire logic                          sda_in,
	output logic                               sda_out,
	output logic                               sda_oe_n,
	input  wire logic [icce_pkg::MODE_W-1:0]   port_mode_select,
	input  wire logic                          start_irq_enable,
	input  wire logic                          stop_irq_enable,
	input  wire logic                          address_hold_enable,
	input  wire logic                          data_hold_enable,
	input  wire logic                          ack_value_select,
	input  wire logic                          buffer_overwrite_enable,
	input  wire logic                          stretch_enable,
	input  wire logic                          client_collision_detect_enable,
	input  wire logic [icce_pkg::BYTE_W-1:0]   own_addr_wdata,
	input  wire logic                          own_addr_we,
	input  wire logic [icce_pkg::BYTE_W-1:0]   buf_wdata,
	input  wire logic                          buf_we,
	input  wire logic                          buf_re,
	input  wire logic                          clock_release_set,
	input  wire logic                          serial_event_clr,
	input  wire logic                          overflow_clr,
	input  wire logic                          bus_collision_clr,
	output logic [icce_pkg::BYTE_W-1:0]        own_address_reg,
	output logic [icce_pkg::BYTE_W-1:0]        shift_buffer_reg,
	output logic                               serial_event_flag,
	output logic                               buffer_full_flag,
	output logic                               receive_overflow_flag,
	output logic                               ack_received_flag,
	output logic                               ack_time_flag,
	output logic                               address_update_flag,
	output logic                               clock_release_bit,
	output logic                               read_write_flag,
	output logic                               start_seen_flag,
	output logic                               stop_seen_flag,
	output logic                               bus_collision_flag
);
	import icce_pkg::*;

	icce_link_if lnk();

	icce_cond u_cond
	(
		.mclk   (mclk),
		.rst    (rst),
		.ce     (ce),
		.scl_in (scl_in),
		.sda_in (sda_in),
		.lnk    (lnk.det)
	);

	icce_match u_match
	(
		.lnk (lnk.cmp)
	);

	icce_state_t             state_reg;
	icce_state_t             state_next;
	icce_kind_t              kind_reg;
	icce_kind_t              kind_next;
	logic [CNT_W-1:0]        cnt_reg;
	logic [CNT_W-1:0]        cnt_next;
	logic [BYTE_W-1:0]       rx_reg;
	logic [BYTE_W-1:0]       rx_next;
	logic [BYTE_W-1:0]       tx_reg;
	logic [BYTE_W-1:0]       tx_next;
	logic                    ack_ok_reg;
	logic                    ack_ok_next;
	logic                    ten_done_reg;
	logic                    ten_done_next;
	logic                    scl_oe_n_next;
	logic                    sda_oe_n_next;
	logic [BYTE_W-1:0]       own_next;
	logic [BYTE_W-1:0]       buf_next;
	logic                    ev_next;
	logic                    bf_next;
	logic                    ov_next;
	logic                    ackr_next;
	logic                    ack_time_flag_next;
	logic                    ua_next;
	logic                    ckp_next;
	logic                    rw_next;
	logic                    ss_next;
	logic                    ps_next;
	logic                    bcl_next;
	logic                    ten;
	logic                    ev_mode;
	logic                    overflow;
	logic                    cur_hold;
	logic                    ack_now;
	logic                    match;
	logic                    hold_req;

	assign lnk.rx_byte  = rx_reg;
	assign lnk.own_addr = own_address_reg;

	// ****************************************************************
	// Decode
	// ****************************************************************
	assign ten      = port_mode_select[MODE_TEN_BIT];
	assign ev_mode  = port_mode_select[MODE_EVENTS];
	assign overflow = buffer_full_flag | receive_overflow_flag;
	assign cur_hold = (kind_reg == KIND_DATA) ? data_hold_enable
		: address_hold_enable;
	assign ack_now  = ack_ok_reg && !(cur_hold && ack_value_select);
	assign hold_req = (!clock_release_bit && state_reg != ST_IDLE)
		|| address_update_flag;

	always_comb
	begin
		unique case (kind_reg)
			KIND_ADDR: match = ten ? (lnk.hi_ok
				&& (!rx_reg[0] || ten_done_reg))
				: lnk.seven_ok;
			KIND_LOW:  match = lnk.low_ok;
			default:   match = 1'b1;
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		state_next    = state_reg;
		kind_next     = kind_reg;
		cnt_next      = cnt_reg;
		rx_next       = rx_reg;
		tx_next       = tx_reg;
		ack_ok_next   = ack_ok_reg;
		ten_done_next = ten_done_reg;
		own_next      = own_address_reg;
		buf_next      = shift_buffer_reg;
		ev_next       = serial_event_flag & ~serial_event_clr;
		bf_next       = buffer_full_flag & ~buf_re;
		ov_next       = receive_overflow_flag & ~overflow_clr;
		ackr_next     = ack_received_flag;
		ack_time_flag_next   = ack_time_flag;
		ua_next       = address_update_flag;
		ckp_next      = clock_release_bit | clock_release_set;
		rw_next       = read_write_flag;
		ss_next       = start_seen_flag;
		ps_next       = stop_seen_flag;
		bcl_next      = bus_collision_flag & ~bus_collision_clr;
		if (own_addr_we)
		begin
			own_next = own_addr_wdata;
			ua_next  = 1'b0;
		end
		if (buf_we)
		begin
			buf_next = buf_wdata;
			tx_next  = buf_wdata;
			bf_next  = 1'b1;
		end
		unique case (state_reg)
			ST_IDLE:
			begin
			end
			ST_RX:
			begin
				if (lnk.scl_rise)
				begin
					rx_next  = {rx_reg[6:0], lnk.sda_s};
					cnt_next = cnt_reg + 4'h1;
				end
				if (lnk.scl_fall && cnt_reg == BITS_PER_BYTE)
				begin
					cnt_next = CNT_RST;
					if (kind_reg == KIND_LOW && !match)
					begin
						ev_next     = 1'b1;
						ua_next     = 1'b1;
						ack_ok_next = 1'b0;
						state_next  = ST_ACK;
					end
					else if (!match)
						state_next = ST_IDLE;
					else
					begin
						if (!overflow || buffer_overwrite_enable)
						begin
							buf_next = rx_reg;
							bf_next  = 1'b1;
						end
						if (overflow)
							ov_next = 1'b1;
						ack_ok_next = !overflow
							|| buffer_overwrite_enable;
						if (kind_reg == KIND_ADDR)
							rw_next = rx_reg[0];
						if (cur_hold)
						begin
							ev_next     = 1'b1;
							ckp_next    = 1'b0;
							ack_time_flag_next = 1'b1;
						end
						state_next = ST_ACK;
					end
				end
			end
			ST_ACK:
			begin
				if (lnk.scl_fall)
				begin
					ack_time_flag_next = 1'b0;
					if (!ack_now)
						state_next = ST_IDLE;
					else
					begin
						ev_next = 1'b1;
						if (kind_reg == KIND_ADDR && ten && !read_write_flag)
						begin
							ua_next    = 1'b1;
							kind_next  = KIND_LOW;
							state_next = ST_RX;
						end
						else if (kind_reg == KIND_LOW)
						begin
							ua_next       = 1'b1;
							ten_done_next = 1'b1;
							kind_next     = KIND_DATA;
							state_next    = ST_RX;
						end
						else if (read_write_flag)
						begin
							ckp_next   = 1'b0;
							state_next = ST_TX;
						end
						else
						begin
							kind_next  = KIND_DATA;
							state_next = ST_RX;
							if (stretch_enable)
								ckp_next = 1'b0;
						end
					end
				end
			end
			ST_TX:
			begin
				if (lnk.scl_rise && client_collision_detect_enable
					&& tx_reg[7] && !lnk.sda_s)
				begin
					bcl_next   = 1'b1;
					state_next = ST_IDLE;
				end
				else if (lnk.scl_fall)
				begin
					tx_next  = {tx_reg[6:0], 1'b0};
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == LAST_TX_FALL)
					begin
						cnt_next   = CNT_RST;
						state_next = ST_TXACK;
					end
				end
			end
			ST_TXACK:
			begin
				if (lnk.scl_rise)
					ackr_next = lnk.sda_s;
				if (lnk.scl_fall)
				begin
					ev_next = 1'b1;
					if (ack_received_flag)
						state_next = ST_IDLE;
					else
					begin
						ckp_next   = 1'b0;
						state_next = ST_TX;
					end
				end
			end
			default:
				state_next = ST_IDLE;
		endcase
		if (lnk.start_det)
		begin
			state_next = ST_RX;
			kind_next  = KIND_ADDR;
			cnt_next   = CNT_RST;
			ss_next    = 1'b1;
			ps_next    = 1'b0;
			if (ev_mode || start_irq_enable)
				ev_next = 1'b1;
		end
		else if (lnk.stop_det)
		begin
			state_next    = ST_IDLE;
			ten_done_next = 1'b0;
			ss_next       = 1'b0;
			ps_next       = 1'b1;
			if (ev_mode || stop_irq_enable)
				ev_next = 1'b1;
		end
		// Open drain: pull only while low is wanted; SCL only once low
		scl_oe_n_next = !(hold_req && (!lnk.scl_s || !scl_oe_n));
		sda_oe_n_next = !((state_reg == ST_ACK && ack_now)
			|| (state_reg == ST_TX && !tx_reg[7]));
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_reg             <= ST_IDLE;
			kind_reg              <= KIND_ADDR;
			cnt_reg               <= CNT_RST;
			rx_reg                <= BYTE_RST;
			tx_reg                <= BYTE_RST;
			ack_ok_reg            <= FLAG_RST;
			ten_done_reg          <= FLAG_RST;
			scl_out               <= PIN_LOW;
			sda_out               <= PIN_LOW;
			scl_oe_n              <= PIN_IDLE_RST;
			sda_oe_n              <= PIN_IDLE_RST;
			own_address_reg       <= BYTE_RST;
			shift_buffer_reg      <= BYTE_RST;
			serial_event_flag     <= FLAG_RST;
			buffer_full_flag      <= FLAG_RST;
			receive_overflow_flag <= FLAG_RST;
			ack_received_flag     <= FLAG_RST;
			ack_time_flag         <= FLAG_RST;
			address_update_flag   <= FLAG_RST;
			clock_release_bit     <= RELEASE_RST;
			read_write_flag       <= FLAG_RST;
			start_seen_flag       <= FLAG_RST;
			stop_seen_flag        <= FLAG_RST;
			bus_collision_flag    <= FLAG_RST;
		end
		else if (ce)
		begin
			state_reg             <= state_next;
			kind_reg              <= kind_next;
			cnt_reg               <= cnt_next;
			rx_reg                <= rx_next;
			tx_reg                <= tx_next;
			ack_ok_reg            <= ack_ok_next;
			ten_done_reg          <= ten_done_next;
			scl_out               <= PIN_LOW;
			sda_out               <= PIN_LOW;
			scl_oe_n              <= scl_oe_n_next;
			sda_oe_n              <= sda_oe_n_next;
			own_address_reg       <= own_next;
			shift_buffer_reg      <= buf_next;
			serial_event_flag     <= ev_next;
			buffer_full_flag      <= bf_next;
			receive_overflow_flag <= ov_next;
			ack_received_flag     <= ackr_next;
			ack_time_flag         <= ack_time_flag_next;
			address_update_flag   <= ua_next;
			clock_release_bit     <= ckp_next;
			read_write_flag       <= rw_next;
			start_seen_flag       <= ss_next;
			stop_seen_flag        <= ps_next;
			bus_collision_flag    <= bcl_next;
		end
	end
endmodule

// *** tb/icce_checker.sv ***
// Purpose: Port assertions of the serial client engine
// Assumes: Sees only the top module ports
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps

module icce_checker
	import icce_pkg::*;
(
	input wire logic                        mclk,
	input wire logic                        rst,
	input wire logic                        ce,
	input wire logic                        scl_out,
	input wire logic                        sda_out,
	input wire logic                        scl_oe_n,
	input wire logic                        address_hold_enable,
	input wire logic                        data_hold_enable,
	input wire logic                        client_collision_detect_enable,
	input wire logic [icce_pkg::BYTE_W-1:0] own_addr_wdata,
	input wire logic                        own_addr_we,
	input wire logic                        clock_release_set,
	input wire logic [icce_pkg::BYTE_W-1:0] own_address_reg,
	input wire logic                        buffer_full_flag,
	input wire logic                        receive_overflow_flag,
	input wire logic                        ack_received_flag,
	input wire logic                        ack_time_flag,
	input wire logic                        address_update_flag,
	input wire logic                        clock_release_bit,
	input wire logic                        read_write_flag,
	input wire logic                        bus_collision_flag
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// ****
	// Assertions
	// ****
	a_pins_open_drain: assert property (!scl_out && !sda_out)
		else $error("pin output value not low");
	a_own_addr_write: assert property (ce && own_addr_we |=>
		own_address_reg == $past(own_addr_wdata))
		else $error("own address not written");
	a_release_cause: assert property ($rose(clock_release_bit) |->
		$past(clock_release_set))
		else $error("release bit set without request");
	a_scl_hold_cause: assert property (!scl_oe_n |->
		!$past(clock_release_bit) || $past(address_update_flag))
		else $error("clock held without cause");
	a_update_stretch: assert property ($rose(address_update_flag) |->
		##[0:8] !scl_oe_n)
		else $error("clock not held for address update");
	a_overflow_cause: assert property ($rose(receive_overflow_flag) |->
		$past(buffer_full_flag))
		else $error("overflow without full buffer");
	a_ack_time_mode: assert property ($rose(ack_time_flag) |->
		address_hold_enable || data_hold_enable)
		else $error("ack time flag outside hold modes");
	a_collision_mode: assert property ($rose(bus_collision_flag) |->
		$past(client_collision_detect_enable))
		else $error("collision flag while detection off");
	a_ack_only_read: assert property ($changed(ack_received_flag) |->
		read_write_flag)
		else $error("host ack latched outside transmit");
endmodule

// *** tb/icce_host_model.sv ***
// Purpose: Behavioural bus host that clocks the client
// Assumes: Open-drain wires resolved by the testbench
// Notes:   SCL low 60 ns, high 20 ns; waits out stretching
`timescale 1ns/1ps

module icce_host_model
(
	input  wire logic scl_bus,
	input  wire logic sda_bus,
	output logic      scl_o,
	output logic      sda_o
);
	int hangs;

	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		hangs = 0;
	end

	// ****
	// Bus actions
	// ****
	task automatic rise;
		int n;
		n = 0;
		scl_o = 1'b1;
		while (scl_bus !== 1'b1 && n < 300)
		begin
			#10;
			n++;
		end
		if (n == 300)
			hangs++;
	endtask

	task automatic pulse(input logic d, output logic q);
		#20;
		sda_o = d;
		#40;
		rise();
		#20;
		q = sda_bus;
		scl_o = 1'b0;
	endtask

	task automatic byte8(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			pulse(w[i], r[i]);
		#20;
		sda_o = 1'b1;
	endtask

	task automatic start;
		#20;
		sda_o = 1'b1;
		#20;
		rise();
		#40;
		sda_o = 1'b0;
		#40;
		scl_o = 1'b0;
	endtask

	task automatic stop;
		#20;
		sda_o = 1'b0;
		#20;
		rise();
		#40;
		sda_o = 1'b1;
		#40;
	endtask
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench of the serial client engine
// Assumes: Host model clocks the bus, bench acts as software
// Notes:   Inputs change 1 ns after the mclk rise
`timescale 1ns/1ps

module testbench;
	import icce_pkg::*;
	logic              mclk, rst, ce, scl_w, sda_w, h_scl, h_sda, q;
	logic              scl_out, scl_oe_n, sda_out, sda_oe_n;
	logic              start_irq_enable, stop_irq_enable;
	logic              address_hold_enable, data_hold_enable;
	logic              ack_value_select, buffer_overwrite_enable;
	logic              stretch_enable, client_collision_detect_enable;
	logic              own_addr_we, buf_we, buf_re, clock_release_set;
	logic              serial_event_clr, overflow_clr, bus_collision_clr;
	logic              serial_event_flag, buffer_full_flag, ack_time_flag;
	logic              receive_overflow_flag, ack_received_flag;
	logic              address_update_flag, clock_release_bit;
	logic              read_write_flag, start_seen_flag, stop_seen_flag;
	logic              bus_collision_flag;
	logic [MODE_W-1:0] port_mode_select;
	logic [BYTE_W-1:0] own_addr_wdata, buf_wdata, own_address_reg;
	logic [BYTE_W-1:0] shift_buffer_reg, r;
	int                errors, comparisons;

	icce_client icce_client_i (.*, .scl_in(scl_w), .sda_in(sda_w));
	icce_host_model host_i (.scl_bus(scl_w), .sda_bus(sda_w),
		.scl_o(h_scl), .sda_o(h_sda));
	assign scl_w = h_scl & (scl_oe_n | scl_out);
	assign sda_w = h_sda & (sda_oe_n | sda_out);

	// ****
	// Helpers
	// ****
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chb(input string n, input logic e, input logic g);
		chk(n, {7'h0, e}, {7'h0, g});
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Release, event clear, buffer read, overflow clear
	task automatic sw(input logic [3:0] k);
		wt(1);
		{clock_release_set, serial_event_clr, buf_re, overflow_clr} = k;
		wt(1);
		{clock_release_set, serial_event_clr, buf_re, overflow_clr} = 4'h0;
	endtask

	task automatic ld(input logic a, input logic [7:0] d);
		wt(1);
		own_addr_we = a;
		buf_we = !a;
		own_addr_wdata = d;
		buf_wdata = d;
		wt(1);
		own_addr_we = 1'b0;
		buf_we = 1'b0;
	endtask

	task automatic addr(input logic [7:0] a);
		sw(4'h7);
		host_i.start();
		host_i.byte8(a, r);
		host_i.pulse(1'b1, q);
		wt(8);
	endtask

	task report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial
	begin
		repeat (100000) @(posedge mclk);
		errors++;
		report_and_stop();
	end

	// ****
	// Tests
	// ****
	initial
	begin
		{rst, ce, start_irq_enable, stop_irq_enable} = 4'he;
		{address_hold_enable, data_hold_enable} = 2'h0;
		{ack_value_select, buffer_overwrite_enable} = 2'h0;
		{stretch_enable, client_collision_detect_enable} = 2'h2;
		{own_addr_we, buf_we, buf_re, clock_release_set} = 4'h0;
		{serial_event_clr, overflow_clr, bus_collision_clr} = 3'h0;
		{own_addr_wdata, buf_wdata, port_mode_select} = 18'h0;
		{errors, comparisons} = 64'h0;
		wt(2);
		rst = 1'b0;
		wt(4);
		chb("release", 1'b1, clock_release_bit);
		ld(1'b1, 8'h54);
		addr(8'h54);
		chb("start event", 1'b1, start_seen_flag);
		chb("addr ack", 1'b0, q);
		chk("addr buf", 8'h54, shift_buffer_reg);
		chb("buf full", 1'b1, buffer_full_flag);
		chb("rw", 1'b0, read_write_flag);
		chb("event", 1'b1, serial_event_flag);
		chb("stretch", 1'b0, scl_oe_n);
		sw(4'hc);
		host_i.byte8(8'h3c, r);
		host_i.pulse(1'b1, q);
		wt(8);
		chb("ovf nack", 1'b1, q);
		chb("ovf flag", 1'b1, receive_overflow_flag);
		host_i.stop();
		wt(8);
		chb("stop", 1'b1, stop_seen_flag);
		$display("test write done");
		start_irq_enable = 1'b0;
		addr(8'h20);
		chb("miss nack", 1'b1, q);
		chb("miss event", 1'b0, serial_event_flag);
		chb("miss scl", 1'b1, scl_oe_n);
		host_i.stop();
		$display("test mismatch done");
		for (int k = 0; k < 2; k++)
		begin
			client_collision_detect_enable = k[0];
			addr(8'h55);
			chb("rd ack", 1'b0, q);
			chb("rd rw", 1'b1, read_write_flag);
			chb("rd hold", 1'b0, clock_release_bit);
			sw(4'h6);
			ld(1'b0, 8'h80 >> k);
			sw(4'h8);
			host_i.byte8(8'hff, r);
			host_i.pulse(k[0], q);
			wt(8);
			chk("tx data", 8'h80 >> k, r);
			chb("host ack", k[0], ack_received_flag);
			chb("tx event", 1'b1, serial_event_flag);
			chb("tx scl", k[0], scl_oe_n);
			if (!k[0])
			begin
				ld(1'b0, 8'h3c);
				sw(4'h8);
				host_i.byte8(8'hff, r);
				host_i.pulse(1'b1, q);
				wt(8);
				chk("tx next", 8'h3c, r);
			end
			host_i.stop();
		end
		addr(8'h55);
		sw(4'h6);
		ld(1'b0, 8'h80);
		sw(4'h8);
		host_i.byte8(8'h00, r);
		host_i.pulse(1'b1, q);
		wt(8);
		chb("collision", 1'b1, bus_collision_flag);
		host_i.stop();
		$display("test read done");
		{address_hold_enable, ack_value_select} = 2'h3;
		sw(4'h7);
		host_i.start();
		host_i.byte8(8'h54, r);
		wt(8);
		chb("ack time", 1'b1, ack_time_flag);
		chb("hold rel", 1'b0, clock_release_bit);
		chb("hold event", 1'b1, serial_event_flag);
		sw(4'he);
		host_i.pulse(1'b1, q);
		wt(8);
		chb("hold nack", 1'b1, q);
		chb("nack event", 1'b0, serial_event_flag);
		host_i.stop();
		{address_hold_enable, ack_value_select} = 2'h0;
		$display("test hold done");
		port_mode_select = 2'h1;
		ld(1'b1, 8'hf6);
		addr(8'hf6);
		chb("hi ack", 1'b0, q);
		chb("ua set", 1'b1, address_update_flag);
		chb("ua scl", 1'b0, scl_oe_n);
		ld(1'b1, 8'h9b);
		sw(4'he);
		wt(4);
		chb("ua clr", 1'b0, address_update_flag);
		chb("ua free", 1'b1, scl_oe_n);
		host_i.byte8(8'h9a, r);
		wt(8);
		chb("lo ua", 1'b1, address_update_flag);
		chb("lo event", 1'b1, serial_event_flag);
		chb("lo scl", 1'b0, scl_oe_n);
		ld(1'b1, 8'hf6);
		host_i.pulse(1'b1, q);
		wt(8);
		chb("lo nack", 1'b1, q);
		host_i.stop();
		$display("test ten bit done");
		port_mode_select = 2'h2;
		sw(4'h4);
		host_i.start();
		wt(8);
		chb("ev start", 1'b1, serial_event_flag);
		sw(4'h4);
		host_i.stop();
		wt(8);
		chb("ev stop", 1'b1, serial_event_flag);
		$display("test event mode done");
		chk("scl hangs", 8'h00, host_i.hangs[7:0]);
		report_and_stop();
	end
endmodule

bind icce_client icce_checker icce_checker_i (.*);
